// ---- shared/csopm_pkg.sv ----
// Constants and carriers for the channel status and output port block.
// Assumes one AHB-Lite slave port with 32-bit data and one clock.
package csopm_pkg;
    localparam int ADDR_W = 8;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_STATUS_A = 6'h01;
    localparam logic [5:0] IDX_STATUS_B = 6'h09;
    localparam logic [5:0] IDX_PIN_FUNC = 6'h0d;
    localparam logic [5:0] IDX_BIT_SET = 6'h0e;
    localparam logic [5:0] IDX_BIT_CLR = 6'h0f;
    localparam logic [5:0] IDX_CTRL = 6'h10;
    localparam logic [5:0] IDX_CMD = 6'h11;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h12;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h13;
    // Control fields: block error mode, ready/full pin select
    localparam int CTRL_BLOCK_A = 0;
    localparam int CTRL_BLOCK_B = 1;
    localparam int CTRL_FULL_A = 2;
    localparam int CTRL_FULL_B = 3;
    // Command fields: error reset, receiver reset
    localparam int CMD_ERR_RST_A = 0;
    localparam int CMD_ERR_RST_B = 1;
    localparam int CMD_RX_RST_A = 2;
    localparam int CMD_RX_RST_B = 3;
    // Pin 3 source codes
    localparam logic [1:0] P3_LATCH = 2'h0;
    localparam logic [1:0] P3_TIMER = 2'h1;
    localparam logic [1:0] P3_TX_CLK = 2'h2;
    localparam logic [1:0] P3_RX_CLK = 2'h3;
    // Receive queue depth for per-character error flags
    localparam int RXQ_DEPTH = 8;
    localparam int PTR_W = $clog2(RXQ_DEPTH);
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] PIN_FUNC_RESET = 8'h00;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ = 2'b10
    } csopm_bus_type;

    // Per-channel link from receiver and transmitter logic
    typedef struct packed {
        logic push;
        logic pop;
        logic brk;
        logic frame_err;
        logic parity_err;
        logic overrun;
        logic transmitter_empty;
        logic transmitter_ready;
        logic receive_fifo_full;
        logic receiver_ready;
    } csopm_link_type;

    typedef struct packed {
        logic [RXQ_DEPTH-1:0][2:0] flags;
        logic [PTR_W-1:0] wr;
        logic [PTR_W-1:0] rd;
        logic [PTR_W:0] cnt;
        logic [2:0] accum;
    } csopm_chan_type;

    typedef struct packed {
        csopm_bus_type phase;
        logic [5:0] idx;
        csopm_chan_type [1:0] chan;
        logic [7:0] pin_func;
        logic [7:0] latch;
        logic [3:0] ctrl;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] rdata;
    } csopm_state_type;
endpackage : csopm_pkg

// ---- hw/csopm_top.sv ----
// Channel status words, error flag queues and output pin function mux.
// Assumes link inputs come from logic on mclk; AHB-Lite single slave.
// Functional notes
// - Status reads break, framing, parity, overrun, tx empty, tx ready, full, rx ready.
// - Error flags travel with each character; status shows the head's flags in character mode.
// - Error reset command clears break, framing and parity flags.
// - Character mode drops a character's flags when it is popped.
// - Block mode accumulates flags until error reset or receiver reset.
// - Pin 7 shows latch bit 7 or channel B transmit ready.
// - Pin 6 shows latch bit 6 or channel A transmit ready.
// - Pin 5 shows latch bit 5 or channel B ready-or-full.
// - Pin 4 shows latch bit 4 or channel A ready-or-full.
// - Pin 3 source: latch, timer, transmit clock or receive clock.
// - Latch bits drive pins inverted: 0 high, 1 low.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module csopm_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [csopm_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire csopm_pkg::csopm_link_type chan_a_link,
    input wire csopm_pkg::csopm_link_type chan_b_link,
    input wire logic timer_out,
    input wire logic chan_a_tx_clk,
    input wire logic chan_a_rx_clk,
    output logic [7:0] output_pins,
    output logic irq
);
    csopm_pkg::csopm_state_type q;
    csopm_pkg::csopm_state_type d;
    csopm_pkg::csopm_link_type link [2];
    logic [1:0][7:0] stat_w;
    logic chan_a_receive_ready_or_full;
    logic chan_b_receive_ready_or_full;

    assign link[0] = chan_a_link;
    assign link[1] = chan_b_link;

    // Head flags or accumulated block flags, then live conditions
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            logic [2:0] err;
            err = 3'h0;
            if (q.ctrl[c]) begin
                err = q.chan[c].accum;
            end else if (q.chan[c].cnt != '0) begin
                err = q.chan[c].flags[q.chan[c].rd];
            end
            stat_w[c] = {err, link[c].overrun, link[c].transmitter_empty,
                link[c].transmitter_ready, link[c].receive_fifo_full,
                link[c].receiver_ready};
        end
    end

    // Reads cost one wait state so hrdata always comes from a flop
    assign hreadyout = (q.phase != csopm_pkg::BUS_READ);
    assign hresp = 1'b0;
    assign hrdata = q.rdata;
    assign irq = |(q.irq_stat & q.irq_mask);

    always_comb begin
        logic wr;
        logic [7:0] wd;
        logic [3:0] cmd;
        logic [1:0] rd_clr;
        wr = (q.phase == csopm_pkg::BUS_WRITE);
        wd = hwdata[7:0];
        cmd = 4'h0;
        rd_clr = 2'h0;
        d = q;
        d.phase = csopm_pkg::BUS_IDLE;
        if (hsel && htrans[1] && hready) begin
            d.idx = haddr[7:2];
            d.phase = hwrite ? csopm_pkg::BUS_WRITE : csopm_pkg::BUS_READ;
        end
        if (wr) begin
            case (q.idx)
                csopm_pkg::IDX_PIN_FUNC: d.pin_func = wd;
                csopm_pkg::IDX_BIT_SET: d.latch = q.latch | wd;
                csopm_pkg::IDX_BIT_CLR: d.latch = q.latch & ~wd;
                csopm_pkg::IDX_CTRL: d.ctrl = wd[3:0];
                csopm_pkg::IDX_CMD: cmd = wd[3:0];
                csopm_pkg::IDX_IRQ_MASK: d.irq_mask = wd[1:0];
                default: ;
            endcase
        end
        if (q.phase == csopm_pkg::BUS_READ) begin
            case (q.idx)
                csopm_pkg::IDX_STATUS_A: d.rdata = {24'h0, stat_w[0]};
                csopm_pkg::IDX_STATUS_B: d.rdata = {24'h0, stat_w[1]};
                csopm_pkg::IDX_PIN_FUNC: d.rdata = {24'h0, q.pin_func};
                csopm_pkg::IDX_CTRL: d.rdata = {28'h0, q.ctrl};
                csopm_pkg::IDX_IRQ_STAT: begin
                    d.rdata = {30'h0, q.irq_stat};
                    rd_clr = 2'h3;
                end
                csopm_pkg::IDX_IRQ_MASK: d.rdata = {30'h0, q.irq_mask};
                default: d.rdata = 32'h0;
            endcase
        end
        d.irq_stat = q.irq_stat & ~rd_clr;
        for (int c = 0; c < 2; c++) begin
            logic push;
            logic pop;
            logic [2:0] err_in;
            push = link[c].push && (q.chan[c].cnt != (csopm_pkg::PTR_W+1)'(csopm_pkg::RXQ_DEPTH));
            pop = link[c].pop && (q.chan[c].cnt != '0);
            err_in = {link[c].brk, link[c].frame_err, link[c].parity_err};
            if (cmd[csopm_pkg::CMD_ERR_RST_A + c] || cmd[csopm_pkg::CMD_RX_RST_A + c]) begin
                d.chan[c].flags = '0;
                d.chan[c].accum = 3'h0;
            end
            if (pop) begin
                if (!q.ctrl[c]) begin
                    d.chan[c].flags[q.chan[c].rd] = 3'h0;
                end
                d.chan[c].rd = q.chan[c].rd + 1'b1;
            end
            // A push in an error reset cycle survives the clear
            if (push) begin
                d.chan[c].flags[q.chan[c].wr] = err_in;
                d.chan[c].wr = q.chan[c].wr + 1'b1;
                d.chan[c].accum = d.chan[c].accum | err_in;
                if (|err_in) begin
                    d.irq_stat[c] = 1'b1;
                end
            end
            d.chan[c].cnt = q.chan[c].cnt + (csopm_pkg::PTR_W+1)'(push)
                - (csopm_pkg::PTR_W+1)'(pop);
            // Receiver reset flushes the queue, including a same-cycle push
            if (cmd[csopm_pkg::CMD_RX_RST_A + c]) begin
                d.chan[c].wr = '0;
                d.chan[c].rd = '0;
                d.chan[c].cnt = '0;
                d.chan[c].flags = '0;
                d.chan[c].accum = 3'h0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            q <= '0;
            q.phase <= csopm_pkg::BUS_IDLE;
            q.pin_func <= csopm_pkg::PIN_FUNC_RESET;
            q.latch <= csopm_pkg::LATCH_RESET;
            q.ctrl <= csopm_pkg::CTRL_RESET;
            q.irq_mask <= csopm_pkg::IRQ_MASK_RESET;
        end else begin
            q <= d;
        end
    end

    assign chan_a_receive_ready_or_full = q.ctrl[csopm_pkg::CTRL_FULL_A]
        ? chan_a_link.receive_fifo_full : chan_a_link.receiver_ready;
    assign chan_b_receive_ready_or_full = q.ctrl[csopm_pkg::CTRL_FULL_B]
        ? chan_b_link.receive_fifo_full : chan_b_link.receiver_ready;

    // Function outputs show the signal itself, not inverted
    always_comb begin
        output_pins = ~q.latch;
        if (q.pin_func[7]) begin
            output_pins[7] = chan_b_link.transmitter_ready;
        end
        if (q.pin_func[6]) begin
            output_pins[6] = chan_a_link.transmitter_ready;
        end
        if (q.pin_func[5]) begin
            output_pins[5] = chan_b_receive_ready_or_full;
        end
        if (q.pin_func[4]) begin
            output_pins[4] = chan_a_receive_ready_or_full;
        end
        case (q.pin_func[3:2])
            csopm_pkg::P3_TIMER: output_pins[3] = timer_out;
            csopm_pkg::P3_TX_CLK: output_pins[3] = chan_a_tx_clk;
            csopm_pkg::P3_RX_CLK: output_pins[3] = chan_a_rx_clk;
            default: output_pins[3] = ~q.latch[3];
        endcase
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    logic [3:0] live_a;
    logic wr_cmd_a;
    assign live_a = {chan_a_link.transmitter_empty, chan_a_link.transmitter_ready,
        chan_a_link.receive_fifo_full, chan_a_link.receiver_ready};
    assign wr_cmd_a = (q.phase == csopm_pkg::BUS_WRITE) && (q.idx == csopm_pkg::IDX_CMD)
        && hwdata[0];

    sequence s_rd_status_a;
        hsel && htrans[1] && hready && !hwrite && (haddr[7:2] == csopm_pkg::IDX_STATUS_A);
    endsequence
    sequence s_wait_then_ready;
        !hreadyout ##1 hreadyout;
    endsequence

    AST_READ_ONE_WAIT: assert property (s_rd_status_a |=> s_wait_then_ready)
        else $error("read did not take exactly one wait state");
    AST_STATUS_LIVE: assert property (s_rd_status_a |=> ##1 hrdata[3:0] == $past(live_a))
        else $error("status live bits wrong");
    AST_HEAD_FLAGS: assert property (!q.ctrl[0] && q.chan[0].cnt == '0 && chan_a_link.push
        && !wr_cmd_a |=> stat_w[0][7:5] == $past({chan_a_link.brk, chan_a_link.frame_err,
        chan_a_link.parity_err}))
        else $error("head error flags not reported");
    AST_ERR_RESET: assert property (wr_cmd_a && !chan_a_link.push |=> stat_w[0][7:5] == 3'h0)
        else $error("error reset did not clear flags");
    AST_CHAR_POP: assert property (!q.ctrl[0] && q.chan[0].cnt == (csopm_pkg::PTR_W+1)'(1) && chan_a_link.pop
        && !chan_a_link.push |=> stat_w[0][7:5] == 3'h0)
        else $error("popped character flags kept");
    AST_BLOCK_HOLD: assert property (q.ctrl[0] && chan_a_link.pop && !chan_a_link.push
        && q.phase != csopm_pkg::BUS_WRITE |=> $stable(stat_w[0][7:5]))
        else $error("block flags changed on pop");
    AST_PIN7_FUNC: assert property (q.pin_func[7] |-> output_pins[7] == chan_b_link.transmitter_ready)
        else $error("pin 7 not transmit ready B");
    AST_PIN6_FUNC: assert property (q.pin_func[6] |-> output_pins[6] == chan_a_link.transmitter_ready)
        else $error("pin 6 not transmit ready A");
    AST_PIN5_FUNC: assert property (q.pin_func[5] && !q.ctrl[3]
        |-> output_pins[5] == chan_b_link.receiver_ready)
        else $error("pin 5 not ready B");
    AST_PIN4_FUNC: assert property (q.pin_func[4] && q.ctrl[2]
        |-> output_pins[4] == chan_a_link.receive_fifo_full)
        else $error("pin 4 not full A");
    AST_PIN3_TIMER: assert property (q.pin_func[3:2] == 2'h1 |-> output_pins[3] == timer_out)
        else $error("pin 3 not timer");
    AST_SET_LOW: assert property ((q.phase == csopm_pkg::BUS_WRITE)
        && (q.idx == csopm_pkg::IDX_BIT_SET) && hwdata[0] |=> !output_pins[0])
        else $error("set bit did not drive pin low");
    AST_CLR_HIGH: assert property ((q.phase == csopm_pkg::BUS_WRITE)
        && (q.idx == csopm_pkg::IDX_BIT_CLR) && hwdata[1] && !hwdata[0]
        |=> output_pins[1] && (output_pins[0] == $past(output_pins[0])))
        else $error("clear port wrong");
endmodule : csopm_top
`default_nettype wire

// ---- sim/csopm_host.sv ----
// Host processor model: a single AHB-Lite master doing word transfers.
// Assumes one slave whose hreadyout comes back as hready.
`timescale 1ns/100ps
`default_nettype none
module csopm_host (
    input wire logic mclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [csopm_pkg::ADDR_W-1:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // Hready and read data are taken at the rising edge, never assumed
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
            output logic [31:0] rd);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask : xfer
endmodule : csopm_host
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the channel status and output port block.
// Assumes the host model owns the bus and the bench drives the link inputs.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic mclk;
    logic reset_n;
    logic hsel;
    logic [csopm_pkg::ADDR_W-1:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    csopm_pkg::csopm_link_type a_link;
    csopm_pkg::csopm_link_type b_link;
    logic timer_out;
    logic tx_clk;
    logic rx_clk;
    logic [7:0] pins;
    logic irq;
    logic [31:0] rd;
    int num_errors;
    int comparisons;

    csopm_top uut (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .chan_a_link(a_link),
        .chan_b_link(b_link), .timer_out, .chan_a_tx_clk(tx_clk), .chan_a_rx_clk(rx_clk),
        .output_pins(pins), .irq);
    csopm_host host (.mclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata);

    task automatic finish_test();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        host.xfer(1'b1, idx, {24'h0, d}, rd);
    endtask : wr
    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        host.xfer(1'b0, idx, 32'h0, rd);
        check(rd, {24'h0, exp});
    endtask : rd_chk
    // Pins and irq settle after the edge, so look half a cycle later
    task automatic pin_chk(input logic [7:0] exp, input logic irq_exp);
        @(negedge mclk);
        check({22'h0, hresp, irq, pins}, {22'h0, 1'b0, irq_exp, exp});
    endtask : pin_chk
    task automatic link_a(input logic push, input logic pop, input logic [2:0] f);
        @(posedge mclk);
        a_link.push <= push;
        a_link.pop <= pop;
        {a_link.brk, a_link.frame_err, a_link.parity_err} <= f;
        @(posedge mclk);
        a_link.push <= 1'b0;
        a_link.pop <= 1'b0;
    endtask : link_a

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        finish_test();
    end
    initial begin
        num_errors = 0;
        comparisons = 0;
        reset_n = 1'b0;
        a_link = '0;
        b_link = '0;
        {a_link.overrun, a_link.transmitter_empty, a_link.transmitter_ready} = 3'h7;
        a_link.receive_fifo_full = 1'b1;
        b_link.transmitter_ready = 1'b1;
        b_link.receiver_ready = 1'b1;
        {timer_out, tx_clk, rx_clk} = 3'h5;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        pin_chk(8'hff, 1'b0);
        rd_chk(csopm_pkg::IDX_STATUS_A, 8'h1e);
        rd_chk(csopm_pkg::IDX_STATUS_B, 8'h05);
        rd_chk(6'h3f, 8'h00);
        wr(csopm_pkg::IDX_BIT_SET, 8'h81);
        pin_chk(8'h7e, 1'b0);
        wr(csopm_pkg::IDX_BIT_CLR, 8'h01);
        pin_chk(8'h7f, 1'b0);
        wr(csopm_pkg::IDX_BIT_SET, 8'h70);
        wr(csopm_pkg::IDX_PIN_FUNC, 8'hf0);
        pin_chk(8'hef, 1'b0);
        wr(csopm_pkg::IDX_CTRL, 8'h04);
        b_link.transmitter_ready <= 1'b0;
        pin_chk(8'h7f, 1'b0);
        // Pin 3 sources: latch 0 gives high, then timer 1, tx clock 0, rx clock 1
        for (int c = 0; c < 4; c++) begin
            wr(csopm_pkg::IDX_PIN_FUNC, {4'h0, c[1:0], 2'h0});
            pin_chk({4'h0, c[0] | (c == 0), 3'h7}, 1'b0);
        end
        link_a(1'b1, 1'b0, 3'b100);
        link_a(1'b1, 1'b0, 3'b001);
        rd_chk(csopm_pkg::IDX_STATUS_A, 8'h9e);
        link_a(1'b0, 1'b1, 3'b000);
        rd_chk(csopm_pkg::IDX_STATUS_A, 8'h3e);
        link_a(1'b0, 1'b1, 3'b000);
        rd_chk(csopm_pkg::IDX_STATUS_A, 8'h1e);
        link_a(1'b1, 1'b0, 3'b010);
        rd_chk(csopm_pkg::IDX_STATUS_A, 8'h5e);
        wr(csopm_pkg::IDX_CMD, 8'h01);
        rd_chk(csopm_pkg::IDX_STATUS_A, 8'h1e);
        link_a(1'b0, 1'b1, 3'b000);
        wr(csopm_pkg::IDX_CTRL, 8'h05);
        link_a(1'b1, 1'b0, 3'b100);
        link_a(1'b1, 1'b0, 3'b001);
        link_a(1'b0, 1'b1, 3'b000);
        link_a(1'b0, 1'b1, 3'b000);
        rd_chk(csopm_pkg::IDX_STATUS_A, 8'hbe);
        wr(csopm_pkg::IDX_CMD, 8'h01);
        rd_chk(csopm_pkg::IDX_STATUS_A, 8'h1e);
        link_a(1'b1, 1'b0, 3'b010);
        wr(csopm_pkg::IDX_CMD, 8'h04);
        rd_chk(csopm_pkg::IDX_STATUS_A, 8'h1e);
        // Channel B: one framing error, then its own error reset
        @(posedge mclk);
        b_link.push <= 1'b1;
        b_link.frame_err <= 1'b1;
        @(posedge mclk);
        b_link.push <= 1'b0;
        b_link.frame_err <= 1'b0;
        rd_chk(csopm_pkg::IDX_STATUS_B, 8'h41);
        wr(csopm_pkg::IDX_CMD, 8'h02);
        rd_chk(csopm_pkg::IDX_STATUS_B, 8'h01);
        wr(csopm_pkg::IDX_PIN_FUNC, 8'h20);
        wr(csopm_pkg::IDX_CTRL, 8'h0d);
        b_link.receive_fifo_full <= 1'b1;
        b_link.receiver_ready <= 1'b0;
        pin_chk(8'h2f, 1'b0);
        // Errors above latched both interrupt bits while they were masked
        wr(csopm_pkg::IDX_IRQ_MASK, 8'h01);
        pin_chk(8'h2f, 1'b1);
        rd_chk(csopm_pkg::IDX_IRQ_MASK, 8'h01);
        rd_chk(csopm_pkg::IDX_CTRL, 8'h0d);
        rd_chk(csopm_pkg::IDX_IRQ_STAT, 8'h03);
        pin_chk(8'h2f, 1'b0);
        // Mid-run reset must drop latch, functions and queues
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        pin_chk(8'hff, 1'b0);
        rd_chk(csopm_pkg::IDX_PIN_FUNC, 8'h00);
        rd_chk(csopm_pkg::IDX_STATUS_B, 8'h02);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
